/* File: hdl/nvcs_cfg.svh */
/*
 * register offsets, field positions, reset values and commands for the
 * memory command and busy-status block.
 * assumes inclusion by bare name from the decoder and top design files.
 */
`ifndef NVCS_CFG_SVH
`define NVCS_CFG_SVH

`define NVCS_OFS_STATUS      6'h32
`define NVCS_OFS_COMMAND     6'h33
`define NVCS_BUSY_BIT        7
`define NVCS_CMD_MSB         5
`define NVCS_CMD_RESET       6'h00
`define NVCS_CMD_NOP         6'h00
`define NVCS_CMD_CHIP_ERASE  6'h10
`define NVCS_CMD_SECT_ERASE  6'h14
`define NVCS_CMD_WORD_WRITE  6'h1D

`endif

/* File: hdl/nvcs_pkg.sv */
/*
 * types for the memory command and busy-status block.
 * assumes the constants header sits beside it.
 */
`default_nettype none
package nvcs_pkg;
    typedef enum logic [1:0] {
        NVCS_OP_NONE,
        NVCS_OP_CHIP_ERASE,
        NVCS_OP_SECT_ERASE,
        NVCS_OP_WORD_WRITE
    } nvcs_op_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } nvcs_io_req_t;

    typedef struct packed {
        logic       wr;
        logic       high;
        logic [7:0] wdata;
    } nvcs_mem_wr_t;

    typedef struct packed {
        logic       start;
        nvcs_op_t   op;
        logic [15:0] word;
    } nvcs_launch_t;
endpackage
`default_nettype wire

/* File: hdl/nvcs_decode.sv */
/*
 * command decoder: maps the command field to an operation.
 * assumes a stable command input; purely combinational.
 */
`include "nvcs_cfg.svh"
`default_nettype none
module nvcs_decode (
    // command in
    input  wire logic [5:0]      cmd_i,
    // operation out
    output var  nvcs_pkg::nvcs_op_t op_o
);
    always_comb
    begin
        case (cmd_i)
            `NVCS_CMD_CHIP_ERASE: op_o = nvcs_pkg::NVCS_OP_CHIP_ERASE; // R6
            `NVCS_CMD_SECT_ERASE: op_o = nvcs_pkg::NVCS_OP_SECT_ERASE; // R6
            `NVCS_CMD_WORD_WRITE: op_o = nvcs_pkg::NVCS_OP_WORD_WRITE; // R6
            default:              op_o = nvcs_pkg::NVCS_OP_NONE;       // R5
        endcase
    end
endmodule
`default_nettype wire

/* File: hdl/nvcs_top.sv */
/*
 * memory command register, busy-status register and launch sequencing.
 * assumes the programming interface presents one-cycle i/o and data-space
 * write strobes, and the memory array reports operation done as a pulse.
 */
// Summary of operation
// R1: busy flag, status bit 7, sets when program or erase launches.
// R2: busy flag holds for whole operation, drops only when it finishes.
// R3: busy covers both code flash and lock bit operations.
// R4: command register bits 5:0 read/write, upper bits zero, resets zero.
// R5: command zero means memory writes launch nothing.
// R6: 0x10 chip erase, 0x14 section erase, 0x1D word write.
// R7: word write: low byte buffered, high byte latches both and launches.
// R8: erase launches on dummy high-byte write inside the section.
// R9: programmer waits for busy to clear before new command or write.
`include "nvcs_cfg.svh"
`default_nettype none
module nvcs_top (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rstn_i,
    // i/o register access
    input  wire nvcs_pkg::nvcs_io_req_t io_req_i,
    output logic [7:0]                  io_rdata_o,
    // data-space memory writes
    input  wire nvcs_pkg::nvcs_mem_wr_t mem_wr_i,
    input  wire logic                   mem_lock_i,
    // memory array
    input  wire logic                   op_done_i,
    output var nvcs_pkg::nvcs_launch_t  launch_o,
    output logic                        launch_lock_o,
    output logic                        busy_o
);
    logic [5:0]             cmd_q;
    logic [5:0]             cmd_d;
    logic [7:0]             low_q;
    logic [7:0]             low_d;
    logic                   busy_q;
    logic                   busy_d;
    logic [7:0]             rdata_q;
    logic [7:0]             rdata_d;
    nvcs_pkg::nvcs_launch_t launch_q;
    nvcs_pkg::nvcs_launch_t launch_d;
    logic                   lock_q;
    logic                   lock_d;
    nvcs_pkg::nvcs_op_t     op;
    logic                   go;

    nvcs_decode u_dec (
        .cmd_i (cmd_q),
        .op_o  (op)
    );

    always_comb
    begin
        cmd_d    = cmd_q;
        low_d    = low_q;
        busy_d   = busy_q;
        rdata_d  = 8'h00;
        lock_d   = lock_q;
        launch_d = '0;
        go       = 1'b0;
        if (io_req_i.wr && !busy_q
            && io_req_i.addr == `NVCS_OFS_COMMAND)
        begin
            cmd_d = io_req_i.wdata[`NVCS_CMD_MSB:0]; // R4 R9
        end
        if (mem_wr_i.wr && !busy_q && !mem_wr_i.high)
        begin
            low_d = mem_wr_i.wdata; // R7
        end
        if (mem_wr_i.wr && !busy_q && mem_wr_i.high
            && op != nvcs_pkg::NVCS_OP_NONE)
        begin
            go = 1'b1; // R5 R8
        end
        if (go)
        begin
            launch_d.start = 1'b1;
            launch_d.op    = op;
            launch_d.word  = {mem_wr_i.wdata, low_q}; // R7
            lock_d         = mem_lock_i; // R3
            busy_d         = 1'b1; // R1
        end
        else if (busy_q && op_done_i)
        begin
            busy_d = 1'b0; // R2 R3
        end
        if (io_req_i.rd)
        begin
            case (io_req_i.addr)
                `NVCS_OFS_STATUS:
                    rdata_d[`NVCS_BUSY_BIT] = busy_q; // R1
                `NVCS_OFS_COMMAND:
                    rdata_d = {2'b00, cmd_q}; // R4
                default:
                    rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            cmd_q    <= `NVCS_CMD_RESET; // R4
            low_q    <= 8'h00;
            busy_q   <= 1'b0;
            rdata_q  <= 8'h00;
            launch_q <= '0;
            lock_q   <= 1'b0;
        end
        else
        begin
            cmd_q    <= cmd_d;
            low_q    <= low_d;
            busy_q   <= busy_d;
            rdata_q  <= rdata_d;
            launch_q <= launch_d;
            lock_q   <= lock_d;
        end
    end

    assign io_rdata_o    = rdata_q;
    assign launch_o      = launch_q;
    assign launch_lock_o = lock_q;
    assign busy_o        = busy_q;
endmodule
`default_nettype wire

/* File: tb/nvcs_chk_checker.sv */
/* timing checks on nvcs_top ports.
   assumes one clock and the sync low reset. */
`default_nettype none
module nvcs_chk (
    // watched ports
    input wire logic                   clk_i,
    input wire logic                   rstn_i,
    input wire nvcs_pkg::nvcs_io_req_t io_req_i,
    input wire logic [7:0]             io_rdata_o,
    input wire nvcs_pkg::nvcs_mem_wr_t mem_wr_i,
    input wire logic                   mem_lock_i,
    input wire logic                   op_done_i,
    input wire nvcs_pkg::nvcs_launch_t launch_o,
    input wire logic                   launch_lock_o,
    input wire logic                   busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] c;
    wire        hw = mem_wr_i.wr & mem_wr_i.high & !busy_o;
    wire        cw = io_req_i.wr & io_req_i.addr == 6'h33 & !busy_o;
    always_ff @(posedge clk_i)
        c <= !rstn_i ? 6'h00 : (cw ? io_req_i.wdata[5:0] : c);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_chip_start: assert property (hw && c == 6'h10
        |=> busy_o && launch_o.op == 2'h1) else $error("chip");
    a_sect_start: assert property (hw && c == 6'h14 |=>
        launch_lock_o == $past(mem_lock_i)) else $error("sect");
    a_word_start: assert property (hw && c == 6'h1D |=>
        launch_o.word[15:8] == $past(mem_wr_i.wdata)) else $error("wr");
    a_no_op: assert property (mem_wr_i.wr &&
        !(c inside {6'h10, 6'h14, 6'h1D}) |=> !launch_o.start)
        else $error("nop");
    a_low_byte: assert property (mem_wr_i.wr && !mem_wr_i.high
        |=> !launch_o.start) else $error("low");
    a_busy_hold: assert property (busy_o && !op_done_i |=> busy_o)
        else $error("hold");
    a_busy_drop: assert property (busy_o && op_done_i |=> !busy_o)
        else $error("drop");
    a_cmd_read: assert property (io_req_i.rd && io_req_i.addr == 6'h33
        |=> io_rdata_o == {2'b00, $past(c)}) else $error("cmd");
    a_status_read: assert property (io_req_i.rd
        && io_req_i.addr == 6'h32
        |=> io_rdata_o == {$past(busy_o), 7'h00}) else $error("stat");
endmodule
bind nvcs_top nvcs_chk i_chk (.*);
`default_nettype wire

/* File: tb/nvcs_array.sv */
/* memory array model: done pulse dly_i cycles after start.
   assumes start_i is a one-cycle pulse. */
`default_nettype none
module nvcs_array (
    // launch in, done out
    input  wire logic       clk_i,
    input  wire logic       start_i,
    input  wire logic [3:0] dly_i,
    output var  logic       done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    initial done_o = 1'b0;
    always @(posedge clk_i)
    begin
        done_o <= (n == 1);
        n <= (start_i === 1'b1) ? dly_i : (n > 0 ? n - 1 : 0);
    end
endmodule
`default_nettype wire

/* File: tb/test_nvm_command_status_regs.sv */
/* bench for nvcs_top. assumes nvcs_array answers the launches. */
`default_nettype none
module test_nvm_command_status_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rstn_i = 0, lk = 0, dn, ll, b;
    logic [3:0] dly = 4'h1;
    logic [7:0] rd;
    nvcs_pkg::nvcs_io_req_t io = '0;
    nvcs_pkg::nvcs_mem_wr_t mw = '0;
    nvcs_pkg::nvcs_launch_t l;
    int errors = 0, n_tests = 0;
    nvcs_top i_dut (.clk_i, .rstn_i, .io_req_i(io), .io_rdata_o(rd),
        .mem_wr_i(mw), .mem_lock_i(lk), .op_done_i(dn), .launch_o(l),
        .launch_lock_o(ll), .busy_o(b));
    nvcs_array i_arr (.clk_i, .start_i(l.start), .dly_i(dly), .done_o(dn));
    initial forever #50 clk_i = !clk_i;
    task stop_test;
        if (errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [19:0] g, e);
        n_tests++;
        if (g !== e)
        begin
            $display("CHECK FAILED %0t %h %h", $time, g, e);
            errors++;
        end
    endtask
    task io_a(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i) io <= '{w, !w, a, d};
        @(posedge clk_i) io <= '0;
        #1;
    endtask
    task mem_w(input logic h, input logic [7:0] d, input logic k = 0);
        @(posedge clk_i)
        begin
            mw <= '{1'b1, h, d};
            lk <= k;
        end
        @(posedge clk_i) mw <= '0;
        #1;
    endtask
    task t_cmd(input logic [7:0] d, input logic [5:0] e);
        io_a(1, 6'h33, d);
        io_a(0, 6'h33, 0);
        chk(rd, e);
        mem_w(1, 8'h55);
        chk(l.start, 0);
    endtask
    task t_word;
        io_a(1, 6'h33, 8'h1D);
        mem_w(0, 8'hAB);
        chk(l.start, 0);
        mem_w(1, 8'hCD);
        chk(l, {3'b111, 16'hCDAB});
        repeat (40) if (b) @(posedge clk_i) #1;
        chk(b, 0);
        if (b)
            stop_test;
    endtask
    task t_erase(input logic [5:0] c, input logic [1:0] op, input logic k);
        io_a(1, 6'h33, {2'b00, c});
        mem_w(1, 8'h00, k);
        chk({l.start, l.op, ll}, {1'b1, op, k});
        io_a(1, 6'h33, 0);
        io_a(0, 6'h32, 0);
        chk(rd, 8'h80);
        repeat (40) if (b) @(posedge clk_i) #1;
        if (b)
        begin
            errors++;
            stop_test;
        end
        io_a(0, 6'h33, 0);
        chk(rd, c);
    endtask
    initial
    begin
        repeat (4) @(posedge clk_i);
        rstn_i <= 1;
        t_cmd(8'h00, 6'h00);
        t_cmd(8'hFF, 6'h3F);
        t_word;
        dly = 4'h9;
        t_erase(6'h10, 2'h1, 0);
        t_erase(6'h14, 2'h2, 1);
        stop_test;
    end
endmodule
`default_nettype wire
